// ### rtl/event_select.sv
/*
 * Event selector of one statistics counter: turns the selected event code and the
 * function and tag qualifiers into an increment of 0 to 3 for this cycle.
 * Assumes all event inputs are on the counter clock; purely combinational.
 */
`timescale 1ns/1ps
`default_nettype none

module event_select (
  input wire logic [stat_pkg::SEL_W-1:0] sel_i,
  input wire logic [stat_pkg::FUNC_W-1:0] func_i,
  input wire logic [stat_pkg::TAG_W-1:0] tag_i,
  input wire logic [stat_pkg::FC_W-1:0] fc_th_a_i,
  input wire logic [stat_pkg::FC_W-1:0] fc_th_b_i,
  input wire logic [stat_pkg::RB_W-1:0] rb_th_i,
  input wire logic [stat_pkg::LAT_W-1:0] lat_th_i,
  input wire logic [1:0] tx_dw_i,
  input wire logic [1:0] tx_hdr_dw_i,
  input wire logic [1:0] rx_hdr_dw_i,
  input wire logic tx_tlp_i,
  input wire logic tx_cpl_i,
  input wire logic tx_np_i,
  input wire logic [stat_pkg::FUNC_W-1:0] tx_func_i,
  input wire logic [stat_pkg::TAG_W-1:0] tx_tag_i,
  input wire logic rx_tlp_i,
  input wire logic rx_cpl_good_i,
  input wire logic [stat_pkg::FUNC_W-1:0] rx_func_i,
  input wire logic [stat_pkg::TAG_W-1:0] rx_tag_i,
  input wire logic rx_bad_tlp_i,
  input wire logic fc_stall_i,
  input wire logic retransmit_i,
  input wire logic rb_stall_i,
  input wire logic [stat_pkg::FC_W-1:0] fc_credit_a_i,
  input wire logic [stat_pkg::FC_W-1:0] fc_credit_b_i,
  input wire logic [stat_pkg::RB_W-1:0] retry_level_i,
  input wire logic [stat_pkg::LAT_W-1:0] cpl_latency_i,
  output logic [1:0] inc_o
);
  import stat_pkg::*;

  logic tx_req;
  logic tx_ft_hit;
  logic rx_ft_hit;

  assign tx_req = tx_tlp_i && !tx_cpl_i;
  assign tx_ft_hit = tx_req && (tx_func_i == func_i) && (tx_tag_i == tag_i);
  assign rx_ft_hit = rx_cpl_good_i && (rx_func_i == func_i) && (rx_tag_i == tag_i);

  always_comb begin
    inc_o = 2'h0;
    case (sel_i)
      EV_TX_DWORDS: inc_o = tx_dw_i;
      EV_TX_ALL: inc_o = {1'b0, tx_tlp_i};
      EV_TX_FN0: inc_o = {1'b0, tx_req && (tx_func_i == 5'h00)};
      EV_TX_FN1: inc_o = {1'b0, tx_req && (tx_func_i == 5'h01)};
      EV_TX_NP_FN0: inc_o = {1'b0, tx_req && tx_np_i && (tx_func_i == 5'h00)};
      EV_TX_NP_FN1: inc_o = {1'b0, tx_req && tx_np_i && (tx_func_i == 5'h01)};
      EV_TX_FUNC_TAG: inc_o = {1'b0, tx_ft_hit};
      EV_RX_ALL: inc_o = {1'b0, rx_tlp_i};
      EV_RX_FN0: inc_o = {1'b0, rx_cpl_good_i && (rx_func_i == 5'h00)};
      EV_RX_FUNC_TAG: inc_o = {1'b0, rx_ft_hit};
      EV_CLOCKS: inc_o = 2'h1;
      EV_RX_BAD: inc_o = {1'b0, rx_bad_tlp_i};
      EV_TX_HDR: inc_o = tx_hdr_dw_i;
      EV_RX_HDR: inc_o = rx_hdr_dw_i;
      EV_FC_STALL: inc_o = {1'b0, fc_stall_i};
      EV_RETRANSMIT: inc_o = {1'b0, retransmit_i};
      EV_RB_STALL: inc_o = {1'b0, rb_stall_i};
      EV_FC_A_OVER: inc_o = {1'b0, fc_credit_a_i > fc_th_a_i};
      EV_FC_B_OVER: inc_o = {1'b0, fc_credit_b_i > fc_th_b_i};
      EV_RB_OVER: inc_o = {1'b0, retry_level_i > rb_th_i};
      EV_LAT_OVER: inc_o = {1'b0, cpl_latency_i > lat_th_i};
      default: inc_o = 2'h0;
    endcase
  end

endmodule : event_select

`default_nettype wire

// ### rtl/event_stat_counters.sv
/*
 * Four 32-bit transaction-layer event counters with a classic Wishbone slave.
 * Assumes event inputs come from logic on clk_i and the master holds a request
 * until it sees ack_o.
 */
// The Wishbone interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module event_stat_counters (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [stat_pkg::ADDR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [stat_pkg::DATA_W-1:0] dat_i,
  output logic [stat_pkg::DATA_W-1:0] dat_o,
  output logic ack_o,
  input wire logic [1:0] tx_dw_i,
  input wire logic [1:0] tx_hdr_dw_i,
  input wire logic [1:0] rx_hdr_dw_i,
  input wire logic tx_tlp_i,
  input wire logic tx_cpl_i,
  input wire logic tx_np_i,
  input wire logic [stat_pkg::FUNC_W-1:0] tx_func_i,
  input wire logic [stat_pkg::TAG_W-1:0] tx_tag_i,
  input wire logic rx_tlp_i,
  input wire logic rx_cpl_good_i,
  input wire logic [stat_pkg::FUNC_W-1:0] rx_func_i,
  input wire logic [stat_pkg::TAG_W-1:0] rx_tag_i,
  input wire logic rx_bad_tlp_i,
  input wire logic fc_stall_i,
  input wire logic retransmit_i,
  input wire logic rb_stall_i,
  input wire logic [stat_pkg::FC_W-1:0] fc_credit_a_i,
  input wire logic [stat_pkg::FC_W-1:0] fc_credit_b_i,
  input wire logic [stat_pkg::RB_W-1:0] retry_level_i,
  input wire logic [stat_pkg::LAT_W-1:0] cpl_latency_i,
  output logic running_o
);
  import stat_pkg::*;

  function automatic logic hit(input logic [ADDR_W-1:0] adr, input logic [ADDR_W-1:0] ofs);
    hit = (adr == ofs);
  endfunction : hit

  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old_v,
                                               input logic [DATA_W-1:0] new_v,
                                               input logic [3:0] be);
    logic [DATA_W-1:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    merge = r;
  endfunction : merge

  logic ack_next;
  logic wr_en;
  logic wr_ctrl;
  logic cmd_wr;
  logic clear_cnt;
  logic [DATA_W-1:0] rd_data;
  logic [DATA_W-1:0] ctrl_rd;
  logic [DATA_W-1:0] ctrl_merged;

  logic [DATA_W-1:0] func_tag_reg;
  logic [DATA_W-1:0] event_sel_reg;
  logic [DATA_W-1:0] credit_th_reg;
  logic [DATA_W-1:0] retry_th_reg;
  logic wide_reg;
  logic test_reg;
  logic [NUM_CNT-1:0] enable_reg;
  logic run_reg;

  logic [FC_W-1:0] credit_threshold_a;
  logic [FC_W-1:0] credit_threshold_b;
  logic [RB_W-1:0] retry_buffer_limit;
  logic [LAT_W-1:0] completion_latency_limit;

  logic [DATA_W-1:0] cnt_reg [NUM_CNT];
  logic [DATA_W:0] sum_w [NUM_CNT];
  logic [1:0] ev_inc_w [NUM_CNT];
  logic [NUM_CNT-1:0] active_w;
  logic [NUM_CNT-1:0] wr_cnt_w;

  // Ack follows one cycle after the request is seen and stays for one cycle only.
  assign ack_next = cyc_i && stb_i && !ack_o;
  // Writes take effect on the edge at which the master samples ack high.
  assign wr_en = cyc_i && stb_i && we_i && ack_o;
  assign wr_ctrl = wr_en && hit(adr_i, OFS_CONTROL);
  assign cmd_wr = wr_ctrl && sel_i[CMD_BYTE];
  assign clear_cnt = cmd_wr && dat_i[CLEAR_BIT];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= ack_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= RESET_VALUE;
    end else if (ack_next) begin
      dat_o <= we_i ? RESET_VALUE : rd_data;
    end
  end

  // Command bits read back as zero; only the mode and enable bits are stored.
  always_comb begin
    ctrl_rd = RESET_VALUE;
    ctrl_rd[WIDE_BIT] = wide_reg;
    ctrl_rd[TEST_BIT] = test_reg;
    ctrl_rd[NUM_CNT-1:0] = enable_reg;
  end

  always_comb begin
    rd_data = RESET_VALUE;
    case (adr_i)
      OFS_FUNC_TAG: rd_data = func_tag_reg;
      OFS_CONTROL: rd_data = ctrl_rd;
      OFS_EVENT_SEL: rd_data = event_sel_reg;
      OFS_CREDIT_TH: rd_data = credit_th_reg;
      OFS_RETRY_TH: rd_data = retry_th_reg;
      OFS_COUNT[0]: rd_data = cnt_reg[0];
      OFS_COUNT[1]: rd_data = cnt_reg[1];
      OFS_COUNT[2]: rd_data = cnt_reg[2];
      OFS_COUNT[3]: rd_data = cnt_reg[3];
      default: rd_data = RESET_VALUE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      func_tag_reg <= RESET_VALUE;
      event_sel_reg <= RESET_VALUE;
    end else begin
      if (wr_en && hit(adr_i, OFS_FUNC_TAG)) begin
        func_tag_reg <= merge(func_tag_reg, dat_i, sel_i);
      end
      if (wr_en && hit(adr_i, OFS_EVENT_SEL)) begin
        event_sel_reg <= merge(event_sel_reg, dat_i, sel_i);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      credit_th_reg <= RESET_VALUE;
      retry_th_reg <= RESET_VALUE;
    end else begin
      if (wr_en && hit(adr_i, OFS_CREDIT_TH)) begin
        credit_th_reg <= merge(credit_th_reg, dat_i, sel_i) & CREDIT_MASK;
      end
      if (wr_en && hit(adr_i, OFS_RETRY_TH)) begin
        retry_th_reg <= merge(retry_th_reg, dat_i, sel_i) & RETRY_MASK;
      end
    end
  end

  assign ctrl_merged = merge(ctrl_rd, dat_i, sel_i);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wide_reg <= 1'b0;
      test_reg <= 1'b0;
      enable_reg <= '0;
    end else if (wr_ctrl) begin
      wide_reg <= ctrl_merged[WIDE_BIT];
      test_reg <= ctrl_merged[TEST_BIT];
      enable_reg <= ctrl_merged[NUM_CNT-1:0];
    end
  end

  // Stop wins when start and stop are written together.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_reg <= 1'b0;
    end else if (cmd_wr && dat_i[STOP_BIT]) begin
      run_reg <= 1'b0;
    end else if (cmd_wr && dat_i[START_BIT]) begin
      run_reg <= 1'b1;
    end
  end

  assign running_o = run_reg;

  // A zero credit threshold stands for 255.
  always_comb begin
    credit_threshold_a = credit_th_reg[FC_A_LSB +: FC_W];
    credit_threshold_b = credit_th_reg[FC_B_LSB +: FC_W];
    if (credit_threshold_a == '0) begin
      credit_threshold_a = FC_ZERO_VALUE;
    end
    if (credit_threshold_b == '0) begin
      credit_threshold_b = FC_ZERO_VALUE;
    end
  end

  assign retry_buffer_limit = retry_th_reg[RB_LSB +: RB_W];
  assign completion_latency_limit = retry_th_reg[LAT_LSB +: LAT_W];

  for (genvar gi = 0; gi < NUM_CNT; gi++) begin : g_cnt
    localparam int LOWER = (gi / 2) * 2;
    localparam bit UPPER = (gi % 2) == 1;
    logic [1:0] step;
    logic lower_carry;

    event_select u_sel (
      .sel_i(event_sel_reg[gi*SEL_W +: SEL_W]),
      .func_i(func_tag_reg[gi*FT_W +: FUNC_W]),
      .tag_i(func_tag_reg[gi*FT_W+TAG_LSB +: TAG_W]),
      .fc_th_a_i(credit_threshold_a),
      .fc_th_b_i(credit_threshold_b),
      .rb_th_i(retry_buffer_limit),
      .lat_th_i(completion_latency_limit),
      .tx_dw_i(tx_dw_i),
      .tx_hdr_dw_i(tx_hdr_dw_i),
      .rx_hdr_dw_i(rx_hdr_dw_i),
      .tx_tlp_i(tx_tlp_i),
      .tx_cpl_i(tx_cpl_i),
      .tx_np_i(tx_np_i),
      .tx_func_i(tx_func_i),
      .tx_tag_i(tx_tag_i),
      .rx_tlp_i(rx_tlp_i),
      .rx_cpl_good_i(rx_cpl_good_i),
      .rx_func_i(rx_func_i),
      .rx_tag_i(rx_tag_i),
      .rx_bad_tlp_i(rx_bad_tlp_i),
      .fc_stall_i(fc_stall_i),
      .retransmit_i(retransmit_i),
      .rb_stall_i(rb_stall_i),
      .fc_credit_a_i(fc_credit_a_i),
      .fc_credit_b_i(fc_credit_b_i),
      .retry_level_i(retry_level_i),
      .cpl_latency_i(cpl_latency_i),
      .inc_o(ev_inc_w[gi])
    );

    // In wide mode the upper half follows the lower half's enable and carry.
    assign active_w[gi] = run_reg && (wide_reg && UPPER ? enable_reg[LOWER] : enable_reg[gi]);
    assign wr_cnt_w[gi] = wr_en && hit(adr_i, OFS_COUNT[gi]);

    // Only an upper half reads a carry, so a lower sum never feeds back into its own step.
    if (UPPER) begin : g_upper
      assign lower_carry = sum_w[LOWER][DATA_W];
    end else begin : g_lower
      assign lower_carry = 1'b0;
    end

    always_comb begin
      step = 2'h0;
      if (active_w[gi]) begin
        if (wide_reg && UPPER) begin
          step = {1'b0, lower_carry};
        end else if (test_reg) begin
          step = 2'h1;
        end else begin
          step = ev_inc_w[gi];
        end
      end
    end

    assign sum_w[gi] = {1'b0, cnt_reg[gi]} + {{(DATA_W-1){1'b0}}, step};

    always_ff @(posedge clk_i) begin
      if (rst_i || clear_cnt) begin
        cnt_reg[gi] <= RESET_VALUE;
      end else if (wr_cnt_w[gi]) begin
        cnt_reg[gi] <= merge(cnt_reg[gi], dat_i, sel_i);
      end else begin
        cnt_reg[gi] <= sum_w[gi][DATA_W-1:0];
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_request;
    cyc_i && stb_i && !ack_o;
  endsequence

  sequence s_stop_write;
    cmd_wr && dat_i[STOP_BIT];
  endsequence

  sequence s_start_write;
    cmd_wr && dat_i[START_BIT] && !dat_i[STOP_BIT];
  endsequence

  sequence s_clear_write;
    cmd_wr && dat_i[CLEAR_BIT];
  endsequence

  a_ack_one_cycle: assert property (s_request |=> ack_o ##1 !ack_o)
    else $error("ack not a single cycle pulse after request");

  a_start_runs: assert property (s_start_write |=> running_o [*2] or (running_o ##1 !running_o))
    else $error("start write did not begin counting");

  a_stop_halts: assert property (s_stop_write |=> !running_o)
    else $error("stop write did not halt counting");

  a_clear_zeroes: assert property (s_clear_write |=> (cnt_reg[0] == '0) && (cnt_reg[1] == '0)
                                   && (cnt_reg[2] == '0) && (cnt_reg[3] == '0))
    else $error("clear write left a counter nonzero");

  a_stopped_holds: assert property (!running_o && !wr_en |=> $stable(cnt_reg[1]))
    else $error("counter moved while stopped");

  a_disabled_holds: assert property (!enable_reg[3] && !wide_reg && !wr_en |=> $stable(cnt_reg[3]))
    else $error("disabled counter moved");

  a_event_adds: assert property (running_o && enable_reg[2] && !wide_reg && !test_reg && !wr_en
                                 |=> cnt_reg[2] == $past(cnt_reg[2]) + 32'($past(ev_inc_w[2])))
    else $error("counter did not add its selected event");

  a_wide_carry: assert property (running_o && wide_reg && enable_reg[0] && !wr_en
                                 && (cnt_reg[0] == 32'hffff_ffff) && (ev_inc_w[0] != 2'h0) && !test_reg
                                 |=> cnt_reg[1] == $past(cnt_reg[1]) + 32'h0000_0001)
    else $error("wide mode carry not passed to upper counter");

  a_func_filter: assert property (running_o && enable_reg[0] && !wide_reg && !test_reg && !wr_en
                                  && (event_sel_reg[7:0] == EV_TX_FUNC_TAG)
                                  && (tx_func_i != func_tag_reg[4:0]) |=> $stable(cnt_reg[0]))
    else $error("function mismatch was counted");

  a_tag_filter: assert property (running_o && enable_reg[0] && !wide_reg && !test_reg && !wr_en
                                 && (event_sel_reg[7:0] == EV_TX_FUNC_TAG)
                                 && (tx_tag_i != func_tag_reg[7:5]) |=> $stable(cnt_reg[0]))
    else $error("tag mismatch was counted");

  a_test_forward: assert property (running_o && enable_reg[1] && !wide_reg && test_reg && !wr_en
                                   |=> cnt_reg[1] == $past(cnt_reg[1]) + 32'h0000_0001)
    else $error("test mode did not forward one per cycle");

endmodule : event_stat_counters

`default_nettype wire

// ### rtl/stat_pkg.sv
/*
 * Shared constants of the transaction-layer statistics counters: register offsets,
 * field positions, reset values and event codes.
 * Assumes byte addressing on a 32-bit classic Wishbone bus, one word per register.
 */
package stat_pkg;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int NUM_CNT = 4;

  localparam logic [ADDR_W-1:0] OFS_FUNC_TAG = 16'h5b08;
  localparam logic [ADDR_W-1:0] OFS_CONTROL = 16'h5b10;
  localparam logic [ADDR_W-1:0] OFS_EVENT_SEL = 16'h5b14;
  localparam logic [ADDR_W-1:0] OFS_CREDIT_TH = 16'h5b18;
  localparam logic [ADDR_W-1:0] OFS_RETRY_TH = 16'h5b1c;
  localparam logic [ADDR_W-1:0] OFS_COUNT [NUM_CNT] = '{16'h5b20, 16'h5b24, 16'h5b28, 16'h5b2c};

  localparam int START_BIT = 31;
  localparam int STOP_BIT = 30;
  localparam int CLEAR_BIT = 29;
  localparam int WIDE_BIT = 28;
  localparam int TEST_BIT = 27;
  localparam int CMD_BYTE = 3;

  localparam int SEL_W = 8;
  localparam int FT_W = 8;
  localparam int FUNC_W = 5;
  localparam int TAG_W = 3;
  localparam int TAG_LSB = 5;

  localparam int FC_W = 12;
  localparam int FC_A_LSB = 0;
  localparam int FC_B_LSB = 16;
  localparam logic [FC_W-1:0] FC_ZERO_VALUE = 12'h0ff;
  localparam int RB_W = 6;
  localparam int RB_LSB = 10;
  localparam int LAT_W = 10;
  localparam int LAT_LSB = 0;

  localparam logic [DATA_W-1:0] RESET_VALUE = 32'h0000_0000;
  localparam logic [DATA_W-1:0] CREDIT_MASK = 32'h0fff_0fff;
  localparam logic [DATA_W-1:0] RETRY_MASK = 32'h0000_ffff;

  localparam logic [SEL_W-1:0] EV_TX_DWORDS = 8'h00;
  localparam logic [SEL_W-1:0] EV_TX_ALL = 8'h01;
  localparam logic [SEL_W-1:0] EV_TX_FN0 = 8'h02;
  localparam logic [SEL_W-1:0] EV_TX_FN1 = 8'h03;
  localparam logic [SEL_W-1:0] EV_TX_NP_FN0 = 8'h04;
  localparam logic [SEL_W-1:0] EV_TX_NP_FN1 = 8'h05;
  localparam logic [SEL_W-1:0] EV_TX_FUNC_TAG = 8'h06;
  localparam logic [SEL_W-1:0] EV_RX_ALL = 8'h1a;
  localparam logic [SEL_W-1:0] EV_RX_FN0 = 8'h1b;
  localparam logic [SEL_W-1:0] EV_RX_FUNC_TAG = 8'h1d;
  localparam logic [SEL_W-1:0] EV_CLOCKS = 8'h20;
  localparam logic [SEL_W-1:0] EV_RX_BAD = 8'h21;
  localparam logic [SEL_W-1:0] EV_TX_HDR = 8'h25;
  localparam logic [SEL_W-1:0] EV_RX_HDR = 8'h26;
  localparam logic [SEL_W-1:0] EV_FC_STALL = 8'h27;
  localparam logic [SEL_W-1:0] EV_RETRANSMIT = 8'h28;
  localparam logic [SEL_W-1:0] EV_RB_STALL = 8'h29;
  localparam logic [SEL_W-1:0] EV_FC_A_OVER = 8'h2a;
  localparam logic [SEL_W-1:0] EV_FC_B_OVER = 8'h2b;
  localparam logic [SEL_W-1:0] EV_RB_OVER = 8'h2c;
  localparam logic [SEL_W-1:0] EV_LAT_OVER = 8'h2d;

endpackage : stat_pkg

// ### verification/testbench.sv
/*
 * Self-checking bench of the event statistics counters: register access, every event
 * code, start, stop, clear, enables, thresholds, wide and test modes.
 * Assumes the design answers each classic Wishbone request with a registered ack.
 */
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import stat_pkg::*;

  typedef struct packed {
    logic [7:0] code;
    logic [79:0] ev;
    logic [31:0] exp;
  } row_t;

  localparam int N = 5;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] be = 4'h0;
  logic [ADDR_W-1:0] adr = 16'h0;
  logic [31:0] wdat = 32'h0;
  logic [79:0] ev = 80'h0;
  logic [31:0] dat_o;
  logic ack_o;
  logic running_o;
  logic [31:0] q;
  int miscompares = 0;
  int n_compared = 0;

  // Stimulus fields of ev: low nibbles are strobes, then func/tag, then monitored levels.
  row_t rows [30] = '{
    '{8'h00, 80'h2, 32'ha}, '{8'h01, 80'h40, 32'h5},
    '{8'h02, 80'h40, 32'h5}, '{8'h03, 80'h1_0040, 32'h5},
    '{8'h02, 80'h1_0040, 32'h0}, '{8'h04, 80'h140, 32'h5},
    '{8'h05, 80'h1_0140, 32'h5}, '{8'h04, 80'h40, 32'h0},
    '{8'h06, 80'h40, 32'h5}, '{8'h06, 80'hc0, 32'h0},
    '{8'h06, 80'h1_0040, 32'h0}, '{8'h06, 80'h20_0040, 32'h0},
    '{8'h1a, 80'h200, 32'h5}, '{8'h1b, 80'h400, 32'h5},
    '{8'h1b, 80'h100_0400, 32'h0}, '{8'h1d, 80'h400, 32'h5},
    '{8'h1d, 80'h2000_0400, 32'h0}, '{8'h21, 80'h800, 32'h5},
    '{8'h25, 80'h8, 32'ha}, '{8'h26, 80'h10, 32'h5},
    '{8'h27, 80'h1000, 32'h5}, '{8'h28, 80'h2000, 32'h5},
    '{8'h29, 80'h4000, 32'h5}, '{8'h1c, 80'h7fff, 32'h0},
    '{8'h2a, 80'h100_0000_0000, 32'h5}, '{8'h2a, 80'h0ff_0000_0000, 32'h0},
    '{8'h2b, 80'h10_0000_0000_0000, 32'h5}, '{8'h2c, 80'h100_0000_0000_0000, 32'h5},
    '{8'h2d, 80'h1_0000_0000_0000_0000, 32'h5}, '{8'h20, 80'h0, 32'h9}};
  row_t th_rows [6] = '{
    '{8'h2a, 80'h301_0000_0000, 32'h5}, '{8'h2a, 80'h300_0000_0000, 32'h0},
    '{8'h2c, 80'h400_0000_0000_0000, 32'h5}, '{8'h2c, 80'h300_0000_0000_0000, 32'h0},
    '{8'h2d, 80'h6_0000_0000_0000_0000, 32'h5}, '{8'h2d, 80'h5_0000_0000_0000_0000, 32'h0}};
  logic [ADDR_W-1:0] regs [10] = '{OFS_FUNC_TAG, OFS_CONTROL, OFS_EVENT_SEL, OFS_CREDIT_TH,
    OFS_RETRY_TH, OFS_COUNT[0], OFS_COUNT[1], OFS_COUNT[2], OFS_COUNT[3], 16'h5b0c};

  event_stat_counters u_event_stat_counters (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(be), .dat_i(wdat), .dat_o(dat_o), .ack_o(ack_o),
    .tx_dw_i(ev[1:0]), .tx_hdr_dw_i(ev[3:2]), .rx_hdr_dw_i(ev[5:4]), .tx_tlp_i(ev[6]),
    .tx_cpl_i(ev[7]), .tx_np_i(ev[8]), .rx_tlp_i(ev[9]), .rx_cpl_good_i(ev[10]),
    .rx_bad_tlp_i(ev[11]), .fc_stall_i(ev[12]), .retransmit_i(ev[13]), .rb_stall_i(ev[14]),
    .tx_func_i(ev[20:16]), .tx_tag_i(ev[23:21]), .rx_func_i(ev[28:24]), .rx_tag_i(ev[31:29]),
    .fc_credit_a_i(ev[43:32]), .fc_credit_b_i(ev[55:44]), .retry_level_i(ev[61:56]),
    .cpl_latency_i(ev[73:64]), .running_o(running_o));

  always #2.5 clk_i = ~clk_i;

  task automatic stop_test;
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : stop_test

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // The request is held until ack is sampled high; read data is taken at that edge.
  task automatic wb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                    input logic [3:0] b);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    be <= b;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    wb(1'b1, a, d, 4'hf);
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0, 4'hf);
    check(q, exp);
  endtask : rd

  task automatic run(input logic [31:0] ctrl, input logic [79:0] v);
    wr(OFS_CONTROL, ctrl | (32'h1 << START_BIT));
    @(posedge clk_i);
    ev <= v;
    check({31'h0, running_o}, 32'h1);
    repeat (N) @(posedge clk_i);
    ev <= 80'h0;
    wr(OFS_CONTROL, ctrl | (32'h1 << STOP_BIT));
    @(posedge clk_i);
    check({31'h0, running_o}, 32'h0);
  endtask : run

  task automatic do_row(input row_t r);
    wr(OFS_EVENT_SEL, {4{r.code}});
    wr(OFS_CONTROL, 32'h1 << CLEAR_BIT);
    run(32'h5, r.ev);
    rd(OFS_COUNT[0], r.exp);
    rd(OFS_COUNT[1], 32'h0);
    rd(OFS_COUNT[2], r.exp);
    rd(OFS_COUNT[3], 32'h0);
  endtask : do_row

  initial begin
    repeat (20000) @(posedge clk_i);
    miscompares++;
    stop_test;
  end

  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    check({31'h0, running_o}, 32'h0);
    foreach (regs[i]) rd(regs[i], RESET_VALUE);
    wr(OFS_FUNC_TAG, 32'hffff_ffff);
    wb(1'b1, OFS_FUNC_TAG, 32'h0, 4'h2);
    rd(OFS_FUNC_TAG, 32'hffff_00ff);
    wr(OFS_CREDIT_TH, 32'hffff_ffff);
    rd(OFS_CREDIT_TH, CREDIT_MASK);
    wr(OFS_RETRY_TH, 32'hffff_ffff);
    rd(OFS_RETRY_TH, RETRY_MASK);
    wr(OFS_CONTROL, 32'hf800_000f);
    rd(OFS_CONTROL, 32'h1800_000f);
    check({31'h0, running_o}, 32'h0);
    wb(1'b1, OFS_CONTROL, 32'h8000_0001, 4'h7);
    @(posedge clk_i);
    check({31'h0, running_o}, 32'h0);
    wr(16'h5b0c, 32'hffff_ffff);
    rd(16'h5b0c, 32'h0);
    wr(OFS_COUNT[3], 32'h1234_5678);
    rd(OFS_COUNT[3], 32'h1234_5678);
    foreach (regs[i]) wr(regs[i], 32'h0);
    foreach (rows[i]) do_row(rows[i]);
    wr(OFS_CREDIT_TH, 32'h0000_0300);
    wr(OFS_RETRY_TH, 32'h0000_0c05);
    foreach (th_rows[i]) do_row(th_rows[i]);
    // Events arriving while stopped must leave the count alone.
    do_row(row_t'{8'h00, 80'h1, 32'h5});
    ev <= 80'h2;
    repeat (N) @(posedge clk_i);
    ev <= 80'h0;
    rd(OFS_COUNT[0], 32'h5);
    wr(OFS_CONTROL, 32'h1 << CLEAR_BIT);
    rd(OFS_COUNT[0], 32'h0);
    wr(OFS_EVENT_SEL, 32'h2100_0001);
    run(32'hf, 80'h840);
    rd(OFS_COUNT[0], 32'h5);
    rd(OFS_COUNT[1], 32'h0);
    rd(OFS_COUNT[3], 32'h5);
    wr(OFS_FUNC_TAG, 32'h0020_0000);
    wr(OFS_EVENT_SEL, 32'h0606_0606);
    wr(OFS_CONTROL, 32'h1 << CLEAR_BIT);
    run(32'h5, 80'h20_0040);
    rd(OFS_COUNT[0], 32'h0);
    rd(OFS_COUNT[2], 32'h5);
    wr(OFS_FUNC_TAG, 32'h0);
    for (int w = 0; w < 2; w++) begin
      wr(OFS_EVENT_SEL, 32'h0000_1c00);
      wr(OFS_CONTROL, 32'h1 << CLEAR_BIT);
      wr(OFS_COUNT[0], 32'hffff_fffe);
      run(32'h3 | (32'(w) << WIDE_BIT), 80'h1);
      rd(OFS_COUNT[0], 32'h3);
      rd(OFS_COUNT[1], 32'(w));
    end
    wr(OFS_EVENT_SEL, 32'h1c1c_1c1c);
    wr(OFS_CONTROL, 32'h1 << CLEAR_BIT);
    run(32'h3 | (32'h1 << TEST_BIT), 80'h0);
    rd(OFS_COUNT[0], 32'h9);
    rd(OFS_COUNT[1], 32'h9);
    rd(OFS_COUNT[2], 32'h0);
    // A reset while counting must return every register and the run state to zero.
    wr(OFS_CONTROL, 32'h8800_0001);
    repeat (N) @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    check({31'h0, running_o}, 32'h0);
    foreach (regs[i]) rd(regs[i], RESET_VALUE);
    stop_test;
  end

endmodule : testbench

`default_nettype wire
